// ==== logic/fmd_decoder.sv ====
// Instruction decoder for a small four-bit core, reached by software over APB.
// Assumes one clock and one reset; instruction words arrive by a register write.
//
// Function
// - The major operation comes from bits 14 to 11 and bit 15 picks register-memory or immediate form.
// - The immediate is one four-bit field used directly as second operand.
// - Bit-test skips carry a four-bit mask choosing which bits of the memory nibble are tested.
// - Branch and call carry the low 11 bits of the target address.
// - The page is PC bit 11 on the small variant or bits 12 and 11 on the large, from rows 1100 to 1111.
// - Peripheral transfers split the address into a 3-bit high and a 4-bit low field.
// - Register file accesses split the address into a 3-bit high and a 4-bit low field.
// - A memory operand is a row field then a column field after the 5-bit operation code.
// - Code 00000 writes register plus memory to the register and 10000 writes memory plus immediate to memory.
// - Codes 00010 and 10010 add the carry flag as well.
// - Code 00001 stores register minus memory and 10001 stores memory minus immediate.
// - Codes 00011 and 10011 subtract the carry flag as well.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module fmd_decoder
  import fmd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  fmd_state_t  state_ff,     nxt_state;
  logic        large_ff,     nxt_large;
  logic [15:0] instr_ff,     nxt_instr;
  logic [3:0]  greg_ff,      nxt_greg;
  logic [3:0]  mem_ff,       nxt_mem;
  logic        carry_flag_ff, nxt_carry_flag;
  logic [3:0]  result_ff,    nxt_result;
  logic        dest_mem_ff,  nxt_dest_mem;
  logic        res_valid_ff, nxt_res_valid;
  logic        skip_ff,      nxt_skip;
  logic [15:0] areg_ff,      nxt_areg;
  logic [11:0] ireg_ff,      nxt_ireg;
  logic [31:0] prdata_ff,    nxt_prdata;
  logic        err_ff,       nxt_err;

  // ---------------------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------------------
  logic        form_imm;
  logic [3:0]  major;
  logic [2:0]  row_field;
  logic [3:0]  column_field;
  logic [3:0]  immediate_nibble;
  logic [3:0]  bit_mask;
  logic [10:0] branch_low;
  logic [1:0]  page;
  logic [12:0] branch_target;
  logic        is_arith;
  logic        is_branch_op;
  logic        is_call;
  logic        is_test;
  logic        is_misc;
  logic [2:0]  periph_addr_high;
  logic [3:0]  periph_addr_low;
  logic        is_periph;
  logic [2:0]  regfile_addr_high;
  logic [3:0]  regfile_addr_low;
  logic        is_regfile;
  logic        skip_if_bits_true;
  logic        skip_if_bits_false;
  logic        bits_true;
  logic        bits_false;

  always_comb begin
    form_imm         = instr_ff[FMD_FORM_BIT];
    major            = instr_ff[FMD_MAJOR_HI:FMD_MAJOR_LO];
    row_field        = instr_ff[FMD_ROW_HI:FMD_ROW_LO];
    column_field     = instr_ff[FMD_COL_HI:FMD_COL_LO];
    immediate_nibble = instr_ff[FMD_LOW_HI:FMD_LOW_LO];
    bit_mask         = instr_ff[FMD_LOW_HI:FMD_LOW_LO];
    branch_low       = instr_ff[FMD_ADDR_HI:0];
    is_arith         = (major[3:2] == 2'b00);
    is_misc          = (major == FMD_MAJ_MISC) && !form_imm;
    // Rows 1100 to 1111 with bit 15 clear are branches; row 1100 with it set is a call.
    is_branch_op     = (major[3:2] == FMD_MAJ_BRANCH_TOP) && !form_imm;
    is_call          = (major[3:2] == FMD_MAJ_BRANCH_TOP) && (major[1:0] == 2'b00) && form_imm;
    // The small variant has no bit 12, so the upper page bit is forced low there.
    page[0]          = instr_ff[FMD_PAGE_BIT0];
    page[1]          = large_ff ? instr_ff[FMD_PAGE_BIT1] : 1'b0;
    branch_target    = {page, branch_low};
    skip_if_bits_true  = form_imm && (major == FMD_MAJ_TEST_T);
    skip_if_bits_false = form_imm && (major == FMD_MAJ_TEST_F);
    is_test          = skip_if_bits_true || skip_if_bits_false;
    bits_true        = ((mem_ff & bit_mask) == bit_mask);
    bits_false       = ((mem_ff & bit_mask) == 4'h0);
    periph_addr_high = instr_ff[FMD_ROW_HI:FMD_ROW_LO];
    periph_addr_low  = instr_ff[FMD_LOW_HI:FMD_LOW_LO];
    is_periph        = is_misc && ((column_field == FMD_SUB_GET) || (column_field == FMD_SUB_PUT));
    regfile_addr_high = instr_ff[FMD_ROW_HI:FMD_ROW_LO];
    regfile_addr_low  = instr_ff[FMD_LOW_HI:FMD_LOW_LO];
    is_regfile       = is_misc && ((column_field == FMD_SUB_PEEK) || (column_field == FMD_SUB_POKE));
  end

  // ---------------------------------------------------------------------------
  // Arithmetic unit
  // ---------------------------------------------------------------------------
  fmd_alu_if alu_bus ();

  // The register form adds memory to the register; the immediate form adds the
  // immediate nibble to memory.
  always_comb begin
    alu_bus.opnd_a    = form_imm ? mem_ff : greg_ff;
    alu_bus.opnd_b    = form_imm ? immediate_nibble : mem_ff;
    alu_bus.carry_in  = carry_flag_ff;
    alu_bus.use_carry = major[1];
    alu_bus.subtract  = major[0];
  end

  fmd_alu u_alu (
    .alu (alu_bus.unit)
  );

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic        setup_phase;
  logic        wr_access;
  logic        hit;
  logic [31:0] rd_word;

  always_comb begin
    setup_phase = psel && !penable;
    wr_access   = psel && penable && pwrite;
    hit         = 1'b1;
    rd_word     = 32'h0000_0000;
    if (paddr == FMD_OFF_CTRL) begin
      rd_word = {31'h0, large_ff};
    end else if (paddr == FMD_OFF_INSTR) begin
      rd_word = {16'h0, instr_ff};
    end else if (paddr == FMD_OFF_OPERAND) begin
      rd_word = {24'h0, mem_ff, greg_ff};
    end else if (paddr == FMD_OFF_FLAGS) begin
      rd_word = {30'h0, state_ff == FMD_ST_EXEC, carry_flag_ff};
    end else if (paddr == FMD_OFF_FIELDS) begin
      rd_word = {12'h0, major[3:2] == 2'b00 && is_arith, is_test, is_regfile, is_periph,
                 instr_ff[FMD_LOW_HI:FMD_LOW_LO], column_field, row_field, form_imm, major};
    end else if (paddr == FMD_OFF_RESULT) begin
      rd_word = {25'h0, skip_ff, res_valid_ff, dest_mem_ff, result_ff};
    end else if (paddr == FMD_OFF_BRANCH) begin
      rd_word = {14'h0, is_call, is_branch_op, 3'h0, branch_target};
    end else if (paddr == FMD_OFF_AREG) begin
      rd_word = {16'h0, areg_ff};
    end else if (paddr == FMD_OFF_IREG) begin
      rd_word = {20'h0, ireg_ff};
    end else if (paddr == FMD_OFF_PERIPH) begin
      rd_word = {10'h0, skip_if_bits_false, skip_if_bits_true, bit_mask,
                 1'b0, regfile_addr_high, regfile_addr_low,
                 1'b0, periph_addr_high, periph_addr_low};
    end else begin
      hit = 1'b0;
    end
  end

  // Read data and the error answer are latched in the setup cycle so that the
  // access cycle presents them from flip-flops with no wait state.
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = err_ff && psel && penable;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state      = state_ff;
    nxt_large      = large_ff;
    nxt_instr      = instr_ff;
    nxt_greg       = greg_ff;
    nxt_mem        = mem_ff;
    nxt_carry_flag = carry_flag_ff;
    nxt_result     = result_ff;
    nxt_dest_mem   = dest_mem_ff;
    nxt_res_valid  = res_valid_ff;
    nxt_skip       = skip_ff;
    nxt_areg       = areg_ff;
    nxt_ireg       = ireg_ff;
    nxt_prdata     = prdata_ff;
    nxt_err        = err_ff;

    if (setup_phase) begin
      nxt_prdata = pwrite ? 32'h0000_0000 : rd_word;
      nxt_err    = !hit;
    end

    if (wr_access && hit) begin
      if (paddr == FMD_OFF_CTRL) begin
        nxt_large = pwdata[0];
      end else if (paddr == FMD_OFF_INSTR) begin
        nxt_instr     = pwdata[15:0];
        nxt_res_valid = 1'b0;
      end else if (paddr == FMD_OFF_OPERAND) begin
        nxt_greg = pwdata[3:0];
        nxt_mem  = pwdata[7:4];
      end else if (paddr == FMD_OFF_FLAGS) begin
        nxt_carry_flag = pwdata[0];
      end else if (paddr == FMD_OFF_AREG) begin
        nxt_areg = pwdata[15:0];
      end else if (paddr == FMD_OFF_IREG) begin
        nxt_ireg = pwdata[11:0];
      end
    end

    case (state_ff)
      FMD_ST_IDLE: begin
        if (wr_access && (paddr == FMD_OFF_INSTR)) begin
          nxt_state = FMD_ST_EXEC;
        end
      end
      FMD_ST_EXEC: begin
        nxt_state = FMD_ST_IDLE;
        nxt_skip  = 1'b0;
        if (is_arith && !major[2]) begin
          // Execution has priority over a software write to the same flag.
          nxt_result     = alu_bus.sum;
          nxt_dest_mem   = form_imm;
          nxt_carry_flag = alu_bus.carry_out;
          nxt_res_valid  = 1'b1;
          if (form_imm) begin
            nxt_mem = alu_bus.sum;
          end else begin
            nxt_greg = alu_bus.sum;
          end
        end else if (instr_ff == FMD_INC_AREG) begin
          nxt_areg = areg_ff + 16'h0001;
        end else if (instr_ff == FMD_INC_IREG) begin
          nxt_ireg = ireg_ff + 12'h001;
        end else if (skip_if_bits_true) begin
          nxt_skip = bits_true;
        end else if (skip_if_bits_false) begin
          nxt_skip = bits_false;
        end
      end
      default: begin
        nxt_state = FMD_ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff      <= FMD_ST_IDLE;
      large_ff      <= 1'b0;
      instr_ff      <= FMD_RST_INSTR;
      greg_ff       <= FMD_RST_NIB;
      mem_ff        <= FMD_RST_NIB;
      carry_flag_ff <= 1'b0;
      result_ff     <= FMD_RST_NIB;
      dest_mem_ff   <= 1'b0;
      res_valid_ff  <= 1'b0;
      skip_ff       <= 1'b0;
      areg_ff       <= FMD_RST_AREG;
      ireg_ff       <= FMD_RST_IREG;
      prdata_ff     <= 32'h0000_0000;
      err_ff        <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      large_ff      <= nxt_large;
      instr_ff      <= nxt_instr;
      greg_ff       <= nxt_greg;
      mem_ff        <= nxt_mem;
      carry_flag_ff <= nxt_carry_flag;
      result_ff     <= nxt_result;
      dest_mem_ff   <= nxt_dest_mem;
      res_valid_ff  <= nxt_res_valid;
      skip_ff       <= nxt_skip;
      areg_ff       <= nxt_areg;
      ireg_ff       <= nxt_ireg;
      prdata_ff     <= nxt_prdata;
      err_ff        <= nxt_err;
    end
  end

endmodule

// ==== logic/fmd_pkg.sv ====
// Constants shared by the four-bit instruction decoder and its arithmetic unit.
// Assumes a 16-bit instruction word whose top five bits are the operation code.
package fmd_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FMD_OFF_CTRL    = 8'h00;
  localparam logic [7:0] FMD_OFF_INSTR   = 8'h04;
  localparam logic [7:0] FMD_OFF_OPERAND = 8'h08;
  localparam logic [7:0] FMD_OFF_FLAGS   = 8'h0C;
  localparam logic [7:0] FMD_OFF_FIELDS  = 8'h10;
  localparam logic [7:0] FMD_OFF_RESULT  = 8'h14;
  localparam logic [7:0] FMD_OFF_BRANCH  = 8'h18;
  localparam logic [7:0] FMD_OFF_AREG    = 8'h1C;
  localparam logic [7:0] FMD_OFF_IREG    = 8'h20;
  localparam logic [7:0] FMD_OFF_PERIPH  = 8'h24;

  // ---------------------------------------------------------------------------
  // Instruction field positions
  // ---------------------------------------------------------------------------
  localparam int FMD_FORM_BIT    = 15;
  localparam int FMD_MAJOR_HI    = 14;
  localparam int FMD_MAJOR_LO    = 11;
  localparam int FMD_ROW_HI      = 10;
  localparam int FMD_ROW_LO      = 8;
  localparam int FMD_COL_HI      = 7;
  localparam int FMD_COL_LO      = 4;
  localparam int FMD_LOW_HI      = 3;
  localparam int FMD_LOW_LO      = 0;
  localparam int FMD_ADDR_HI     = 10;
  localparam int FMD_PAGE_BIT0   = 11;
  localparam int FMD_PAGE_BIT1   = 12;

  // ---------------------------------------------------------------------------
  // Major opcode rows and fixed operand patterns
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  FMD_MAJ_MISC     = 4'h7;
  localparam logic [3:0]  FMD_MAJ_SKNE     = 4'hB;
  localparam logic [3:0]  FMD_MAJ_MOVI     = 4'hD;
  localparam logic [3:0]  FMD_MAJ_TEST_T   = 4'hE;
  localparam logic [3:0]  FMD_MAJ_TEST_F   = 4'hF;
  localparam logic [1:0]  FMD_MAJ_BRANCH_TOP = 2'h3;
  localparam logic [15:0] FMD_INC_AREG     = 16'h3890;
  localparam logic [15:0] FMD_INC_IREG     = 16'h3880;
  localparam logic [3:0]  FMD_SUB_PEEK     = 4'h3;
  localparam logic [3:0]  FMD_SUB_POKE     = 4'h2;
  localparam logic [3:0]  FMD_SUB_GET      = 4'hB;
  localparam logic [3:0]  FMD_SUB_PUT      = 4'hA;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FMD_RST_INSTR = 16'h0000;
  localparam logic [15:0] FMD_RST_AREG  = 16'h0000;
  localparam logic [11:0] FMD_RST_IREG  = 12'h000;
  localparam logic [3:0]  FMD_RST_NIB   = 4'h0;

  typedef enum logic [1:0] {
    FMD_ST_IDLE = 2'b01,
    FMD_ST_EXEC = 2'b10
  } fmd_state_t;

endpackage

// ==== logic/fmd_alu_if.sv ====
// Carries one four-bit arithmetic request and its answer between decoder and unit.
// Assumes both ends sit in the same clock domain; the path is purely combinational.
`timescale 1ns/1ps

interface fmd_alu_if;
  logic [3:0] opnd_a;
  logic [3:0] opnd_b;
  logic       carry_in;
  logic       use_carry;
  logic       subtract;
  logic [3:0] sum;
  logic       carry_out;

  modport requester (
    output opnd_a,
    output opnd_b,
    output carry_in,
    output use_carry,
    output subtract,
    input  sum,
    input  carry_out
  );

  modport unit (
    input  opnd_a,
    input  opnd_b,
    input  carry_in,
    input  use_carry,
    input  subtract,
    output sum,
    output carry_out
  );
endinterface

// ==== logic/fmd_alu.sv ====
// Four-bit adder and subtractor with optional carry or borrow in.
// Assumes the requester registers the answer; nothing here is clocked.
`timescale 1ns/1ps

module fmd_alu
  import fmd_pkg::*;
(
  fmd_alu_if.unit alu
);

  logic       cin_eff;
  logic [4:0] wide;

  // Carry out on add and borrow on subtract both land in bit 4.
  always_comb begin
    cin_eff = alu.use_carry & alu.carry_in;
    if (alu.subtract) begin
      wide = {1'b0, alu.opnd_a} - {1'b0, alu.opnd_b} - {4'h0, cin_eff};
    end else begin
      wide = {1'b0, alu.opnd_a} + {1'b0, alu.opnd_b} + {4'h0, cin_eff};
    end
    alu.sum       = wide[3:0];
    alu.carry_out = wide[4];
  end

endmodule

// ==== dv/fmd_decoder_chk.sv ====
// Checker for the instruction decoder, bound onto its APB ports.
// Assumes zero-wait APB and that read data is latched in the setup cycle.
`timescale 1ns/1ps

module fmd_decoder_chk
  import fmd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ---------------------------------------------------------------------------
  // Shadow of the last written instruction and variant
  // ---------------------------------------------------------------------------
  logic [15:0] instr_ff;
  logic [15:0] nxt_instr;
  logic        large_ff;
  logic        nxt_large;
  logic        wr_acc;
  logic        mapped;

  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= FMD_OFF_PERIPH);

  always_comb begin
    nxt_instr = instr_ff;
    nxt_large = large_ff;
    if (wr_acc && paddr == FMD_OFF_INSTR) nxt_instr = pwdata[15:0];
    if (wr_acc && paddr == FMD_OFF_CTRL) nxt_large = pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff <= 16'h0000;
      large_ff <= 1'b0;
    end else begin
      instr_ff <= nxt_instr;
      large_ff <= nxt_large;
    end
  end

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_read(a, ok);
    s_setup(a) ##1 s_access |-> ok;
  endproperty

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access_only: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_err_unmapped: assert property (psel && !penable && !mapped ##1 s_access |-> pslverr)
    else $error("unmapped access without pslverr");
  a_fields_opcode: assert property (p_read(FMD_OFF_FIELDS, prdata[4:0] == instr_ff[15:11]))
    else $error("opcode field wrong");
  a_fields_operand: assert property (p_read(FMD_OFF_FIELDS,
    prdata[15:5] == {instr_ff[3:0], instr_ff[7:4], instr_ff[10:8]}))
    else $error("operand fields wrong");
  a_periph_split: assert property (p_read(FMD_OFF_PERIPH, prdata[6:0] == {instr_ff[10:8], instr_ff[3:0]}))
    else $error("peripheral address split wrong");
  a_regfile_split: assert property (p_read(FMD_OFF_PERIPH,
    prdata[14:8] == {instr_ff[10:8], instr_ff[3:0]}))
    else $error("register file address split wrong");
  a_mask_field: assert property (p_read(FMD_OFF_PERIPH, prdata[19:16] == instr_ff[3:0]))
    else $error("bit mask field wrong");
  a_branch_addr: assert property (p_read(FMD_OFF_BRANCH, !prdata[16] || prdata[10:0] == instr_ff[10:0]))
    else $error("branch address wrong");
  a_branch_page: assert property (p_read(FMD_OFF_BRANCH,
    prdata[16] == (!instr_ff[15] && instr_ff[14:13] == 2'b11)
    && (!prdata[16] || prdata[12:11] == {large_ff & instr_ff[12], instr_ff[11]})))
    else $error("branch page wrong");
endmodule

bind fmd_decoder fmd_decoder_chk chk (
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr)
);

// ==== dv/fmd_prog_mem.sv ====
// Program memory model handing instruction words to the bench by fetch address.
// Assumes the bench copies each fetched word into the instruction register.
`timescale 1ns/1ps

module fmd_prog_mem (
  input  wire logic [5:0]  fetch_addr,
  output logic      [15:0] fetch_word
);
  // Low addresses hold corner words (branch pages, call, skips, transfers); the rest is a fixed scramble.
  always_comb begin
    case (fetch_addr)
      6'h00:   fetch_word = 16'h6000;
      6'h01:   fetch_word = 16'h7FFF;
      6'h02:   fetch_word = 16'hE3A5;
      6'h03:   fetch_word = 16'hF7F0;
      6'h04:   fetch_word = 16'hF8AF;
      6'h05:   fetch_word = 16'h3DB6;
      6'h06:   fetch_word = 16'h3A2C;
      default: fetch_word = 16'({10'h000, fetch_addr} * 16'h9E37) ^ 16'h5AC3;
    endcase
  end
endmodule

// ==== dv/fmd_decoder_tb.sv ====
// Self-checking bench for the instruction decoder, driven over APB.
// Assumes the checker is bound by its own file and the program memory model is compiled.
`timescale 1ns/1ps

module four_bit_mcu_instruction_decoder_tb_top
  import fmd_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pc      = 6'h00;
  logic [15:0] word;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          seed       = 73602;
  logic [31:0] q;
  logic        e;
  logic [3:0]  g, m, imm, cf;
  logic [7:0]  bad_addr [3] = '{8'h28, 8'h06, 8'hFC};
  logic [11:0] corner   [4] = '{12'hF11, 12'h010, 12'hF01, 12'h001};
  logic [4:0]  r;
  logic [15:0] w;
  logic        lg, bt;

  fmd_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fmd_prog_mem pm (.fetch_addr(pc), .fetch_word(word));

  always #10 pclk = ~pclk;

  // ---------------------------------------------------------------------------
  // Reporting and bus tasks
  // ---------------------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; an idle edge precedes it so psel never changes twice in one step.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      end_of_test;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------------------
  function automatic logic [4:0] alu(input logic [3:0] a, b, input logic c, sub);
    return sub ? {1'b0, a} - {1'b0, b} - {4'h0, c} : {1'b0, a} + {1'b0, b} + {4'h0, c};
  endfunction

  function automatic logic [31:0] f_fields(input logic [15:0] x);
    return {12'h000, x[14:13] == 2'b00, x[15] && x[14:12] == 3'b111,
            x[15:11] == 5'b00111 && x[7:5] == 3'b001, x[15:11] == 5'b00111 && x[7:5] == 3'b101,
            x[3:0], x[7:4], x[10:8], x[15:11]};
  endfunction

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 36; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset read", q, (a == 16) ? f_fields(16'h0000) : 32'h0);
      chk("reset err", 32'(e), 32'h0);
    end
    apb(1'b1, FMD_OFF_FIELDS, 32'hFFFF_FFFF);
    apb(1'b0, FMD_OFF_FIELDS, 32'h0);
    chk("read only", q, f_fields(16'h0000));
    foreach (bad_addr[k]) begin
      apb(1'b1, bad_addr[k], 32'hA5A5_A5A5);
      chk("unmapped write err", 32'(e), 32'h1);
      apb(1'b0, bad_addr[k], 32'h0);
      chk("unmapped read", {q[30:0], e}, 32'h1);
    end
    $display("test reset and map done");
    for (int i = 0; i < 32; i++) begin
      {g, m, imm, cf} = 16'($random(seed));
      if (i < 4) {g, m, cf} = corner[i];
      w = {i[2], 2'b00, i[1:0], 3'($random(seed)), 4'($random(seed)), imm};
      apb(1'b1, FMD_OFF_OPERAND, {24'h0, m, g});
      apb(1'b1, FMD_OFF_FLAGS, {31'h0, cf[0]});
      apb(1'b1, FMD_OFF_INSTR, {16'h0, w});
      r = w[15] ? alu(m, imm, cf[0] & w[12], w[11]) : alu(g, m, cf[0] & w[12], w[11]);
      apb(1'b0, FMD_OFF_RESULT, 32'h0);
      chk("result", {q[31:7], q[6:0]}, {25'h0, 2'b01, w[15], r[3:0]});
      apb(1'b0, FMD_OFF_OPERAND, 32'h0);
      chk("operand", q, {24'h0, w[15] ? {r[3:0], g} : {m, r[3:0]}});
      apb(1'b0, FMD_OFF_FLAGS, 32'h0);
      chk("carry", q, {31'h0, r[4]});
    end
    $display("test arithmetic done");
    for (int i = 0; i < 48; i++) begin
      @(posedge pclk);
      pc <= 6'(i);
      @(posedge pclk);
      w = word;
      lg = 1'($random(seed));
      m = 4'($random(seed));
      apb(1'b1, FMD_OFF_CTRL, {31'h0, lg});
      apb(1'b1, FMD_OFF_OPERAND, {24'h0, m, 4'h0});
      apb(1'b1, FMD_OFF_INSTR, {16'h0, w});
      apb(1'b0, FMD_OFF_FIELDS, 32'h0);
      chk("fields", q, f_fields(w));
      bt = (!w[15] && w[14:13] == 2'b11) || w[15:11] == 5'b11100;
      apb(1'b0, FMD_OFF_BRANCH, 32'h0);
      chk("branch", q & {19'h7FFFF, {13{bt}}}, {14'h0, w[15:11] == 5'b11100, !w[15] && w[14:13] == 2'b11,
          3'h0, bt ? {lg & w[12], w[11:0]} : 13'h0});
      apb(1'b0, FMD_OFF_PERIPH, 32'h0);
      chk("periph", q, {10'h0, w[15:11] == 5'b11111, w[15:11] == 5'b11110, w[3:0], 1'b0, w[10:8], w[3:0],
          1'b0, w[10:8], w[3:0]});
      if (w[15] && w[14:12] == 3'b111) begin
        apb(1'b0, FMD_OFF_RESULT, 32'h0);
        chk("skip", 32'(q[6]), 32'(w[11] ? (m & w[3:0]) == 4'h0 : (m & w[3:0]) == w[3:0]));
      end
    end
    $display("test decode done");
    for (int j = 0; j < 2; j++) begin
      w = j ? 16'($random(seed)) : 16'hFFFF;
      apb(1'b1, FMD_OFF_AREG, {16'h0, w});
      apb(1'b1, FMD_OFF_IREG, {20'h0, ~w[11:0]});
      apb(1'b1, FMD_OFF_INSTR, {16'h0, FMD_INC_AREG});
      apb(1'b0, FMD_OFF_AREG, 32'h0);
      chk("inc areg", q, {16'h0, w + 16'h0001});
      apb(1'b1, FMD_OFF_INSTR, {16'h0, FMD_INC_IREG});
      apb(1'b0, FMD_OFF_IREG, 32'h0);
      chk("inc ireg", q, {20'h0, ~w[11:0] + 12'h001});
      apb(1'b0, FMD_OFF_AREG, 32'h0);
      chk("areg kept", q, {16'h0, w + 16'h0001});
    end
    $display("test increment done");
    end_of_test;
  end
endmodule
